// file: hw/nvm_regs.svh
// Register offsets, field positions, reset values and timing of the nonvolatile access block
//
// Overview of operation
// - Control bits seven to four read zero
// - Ready request held while enabled and idle
// - Write strobe starts write only when armed
// - Arm bit clears itself four cycles later
// - Strobe stays high for whole timed write
// - Write strobe stalls processor two cycles
// - Read strobe fetches byte, clears itself
// - Read strobe stalls processor four cycles
// - Address or data write aborts running write
// - Nine-bit linear address from two registers
// - Data register sources writes, receives reads
`ifndef NVM_REGS_SVH
`define NVM_REGS_SVH

// Register byte offsets on the APB side
`define NVM_OFS_ADDR_LOW   8'h00
`define NVM_OFS_ADDR_HIGH  8'h04
`define NVM_OFS_DATA       8'h08
`define NVM_OFS_CTRL       8'h0C
`define NVM_OFS_IRQ_STATUS 8'h10
`define NVM_OFS_IRQ_MASK   8'h14

// Control register fields
`define NVM_CTRL_READ_BIT  0
`define NVM_CTRL_WRITE_BIT 1
`define NVM_CTRL_ARM_BIT   2
`define NVM_CTRL_RIE_BIT   3

// Event bits shared by status and mask
`define NVM_EVT_WRITE_DONE  0
`define NVM_EVT_READ_DONE   1
`define NVM_EVT_WRITE_ABORT 2

// Reset values
`define NVM_ADDR_RESET 9'h000
`define NVM_DATA_RESET 8'h00
`define NVM_EVT_RESET  3'h0

// Timing
`define NVM_CLK_PERIOD_NS  25
`define NVM_WRITE_TIME_NS  2500000
`define NVM_WRITE_CYCLES   ((`NVM_WRITE_TIME_NS + `NVM_CLK_PERIOD_NS - 1) / `NVM_CLK_PERIOD_NS)
`define NVM_ARM_CYCLES     3'h4
`define NVM_WRITE_STALL    3'h2
`define NVM_READ_STALL     3'h4

`endif

// file: hw/nvm_pkg.sv
// Types shared by the nonvolatile access block
package nvm_pkg;

    // APB request from the bus master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    // Whole state of the access controller
    typedef struct packed {
        logic [8:0]  addr;       // Linear byte address
        logic [7:0]  data;       // Data byte
        logic        rie;        // Ready interrupt enable
        logic        arm;        // Master write arm
        logic [2:0]  arm_cnt;    // Arm timeout count
        logic        wstrobe;    // Write in progress
        logic        rstrobe;    // Read pending
        logic [2:0]  stall_cnt;  // Processor stall count
        logic        stall;      // Processor stall output
        logic [2:0]  status;     // Sticky events
        logic [2:0]  mask;       // Event mask
        logic        rdy_irq;    // Ready request output
        logic        irq;        // Event interrupt output
        logic        pready;     // APB ready
        logic [31:0] prdata;     // APB read data
        logic        pslverr;    // APB error
    } top_state_s;

endpackage

// file: hw/nvm_write_timer.sv
// Self-timed write duration counter
`timescale 1ns/1ps
`default_nettype none
module nvm_write_timer #(
    parameter int WIDTH  = 17,
    parameter int CYCLES = 100000
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Control
    input  wire logic start,
    input  wire logic abort,
    // Status
    output logic      done
);
    typedef struct packed {
        logic [WIDTH-1:0] count;  // Remaining cycles, zero when idle
    } timer_state_s;

    localparam logic [WIDTH-1:0] LOAD = WIDTH'(CYCLES);
    localparam logic [WIDTH-1:0] ONE  = WIDTH'(1);

    timer_state_s state_ff;
    timer_state_s nxt_state;

    // Last cycle of a running write ends it, unless it is being aborted
    assign done = (state_ff.count == ONE) && !abort;

    // Load, abort or count down
    always_comb begin
        nxt_state = state_ff;
        if (abort) begin
            nxt_state.count = '0;
        end else if (start) begin
            nxt_state.count = LOAD;
        end else if (state_ff.count != '0) begin
            nxt_state.count = state_ff.count - ONE;
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule // nvm_write_timer
`default_nettype wire

// file: hw/nvm_array.sv
// Byte-wide nonvolatile storage modelled in flip-flops
`timescale 1ns/1ps
`default_nettype none
module nvm_array #(
    parameter int ADDR_W = 9,
    parameter int DATA_W = 8
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Access port
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata
);
    typedef struct packed {
        logic [(1<<ADDR_W)-1:0][DATA_W-1:0] mem;  // Cells
        logic [DATA_W-1:0]                  rdata;  // Registered read
    } array_state_s;

    array_state_s state_ff;
    array_state_s nxt_state;

    assign rdata = state_ff.rdata;

    // Read every cycle; commit a byte on write enable
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rdata = state_ff.mem[addr];
        if (wr_en) begin
            nxt_state.mem[addr] = wdata;
        end
    end

    // Cells clear on reset; real content would survive it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule // nvm_array
`default_nettype wire

// file: hw/eeprom_access_control.sv
// Access controller for the byte-wide nonvolatile data memory, with APB registers
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_regs.svh"
module eeprom_access_control #(
    parameter int WRITE_CYCLES = `NVM_WRITE_CYCLES,
    parameter int TIMER_W      = 17
) (
    // Clock and reset
    input  wire  logic              core_clk,
    input  wire  logic              rst,
    // APB slave
    input  wire  nvm_pkg::apb_req_s apb_req,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Processor side
    input  wire  logic              global_irq_enable,
    output logic                    cpu_stall,
    output logic                    ready_irq_req,
    output logic                    irq
);
    import nvm_pkg::*;

    top_state_s state_ff;     // Registered state
    top_state_s nxt_state;    // Next state
    logic       timer_start;  // Write launched this cycle
    logic       timer_abort;  // Write cancelled this cycle
    logic       timer_done;   // Write completes this cycle
    logic [7:0] arr_rdata;    // Byte at current address
    logic       acc;          // APB access phase
    logic       xfer;         // APB transfer completes
    logic       wr;           // Completed write transfer
    logic       wr_ctrl;      // Completed write to control

    // Decode of the register map, shared by reads and writes
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `NVM_OFS_ADDR_LOW) || (a == `NVM_OFS_ADDR_HIGH) ||
                    (a == `NVM_OFS_DATA) || (a == `NVM_OFS_CTRL) ||
                    (a == `NVM_OFS_IRQ_STATUS) || (a == `NVM_OFS_IRQ_MASK);
    endfunction

    // Offsets whose write cancels a running write
    function automatic logic aborts_write(input logic [7:0] a);
        aborts_write = (a == `NVM_OFS_ADDR_LOW) || (a == `NVM_OFS_ADDR_HIGH) ||
                       (a == `NVM_OFS_DATA);
    endfunction

    // Read view of one register word
    function automatic logic [31:0] read_word(input logic [7:0] a, input top_state_s s);
        read_word = 32'h0000_0000;
        unique case (a)
            `NVM_OFS_ADDR_LOW:   read_word[7:0] = s.addr[7:0];
            `NVM_OFS_ADDR_HIGH:  read_word[0] = s.addr[8];
            `NVM_OFS_DATA:       read_word[7:0] = s.data;
            `NVM_OFS_CTRL: begin
                // Upper control bits are left at zero
                read_word[`NVM_CTRL_RIE_BIT]   = s.rie;
                read_word[`NVM_CTRL_ARM_BIT]   = s.arm;
                read_word[`NVM_CTRL_WRITE_BIT] = s.wstrobe;
                read_word[`NVM_CTRL_READ_BIT]  = s.rstrobe;
            end
            `NVM_OFS_IRQ_STATUS: read_word[2:0] = s.status;
            `NVM_OFS_IRQ_MASK:   read_word[2:0] = s.mask;
            default:             read_word = 32'h0000_0000;
        endcase
    endfunction

    // Bus phase decode
    assign acc     = apb_req.psel && apb_req.penable;
    assign xfer    = acc && state_ff.pready;
    assign wr      = xfer && apb_req.pwrite;
    assign wr_ctrl = wr && (apb_req.paddr == `NVM_OFS_CTRL);

    // Outputs come straight from the state register
    assign prdata        = state_ff.prdata;
    assign pready        = state_ff.pready;
    assign pslverr       = state_ff.pslverr;
    assign cpu_stall     = state_ff.stall;
    assign ready_irq_req = state_ff.rdy_irq;
    assign irq           = state_ff.irq;

    // Duration of the self-timed write
    nvm_write_timer #(
        .WIDTH  (TIMER_W),
        .CYCLES (WRITE_CYCLES)
    ) u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (timer_start),
        .abort    (timer_abort),
        .done     (timer_done)
    );

    // Storage; the byte is committed when the write time has run out
    nvm_array #(
        .ADDR_W (9),
        .DATA_W (8)
    ) u_array (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (timer_done),
        .addr     (state_ff.addr),
        .wdata    (state_ff.data),
        .rdata    (arr_rdata)
    );

    // All next-state logic of the controller
    always_comb begin
        logic [2:0] evt;   // Events raised this cycle
        logic [2:0] clr;   // Status bits cleared by software
        nxt_state   = state_ff;
        evt         = `NVM_EVT_RESET;
        clr         = `NVM_EVT_RESET;
        timer_start = 1'b0;
        timer_abort = 1'b0;

        // One wait state lets read data come from a flip-flop
        nxt_state.pready = acc && !state_ff.pready;
        if (acc && !state_ff.pready) begin
            nxt_state.prdata  = read_word(apb_req.paddr, state_ff);
            nxt_state.pslverr = !is_mapped(apb_req.paddr);
        end

        // Arm times out on its own so a stray strobe later cannot write
        if (state_ff.arm_cnt != 3'h0) begin
            nxt_state.arm_cnt = state_ff.arm_cnt - 3'h1;
            if (state_ff.arm_cnt == 3'h1) begin
                nxt_state.arm = 1'b0;
            end
        end

        // Processor stall countdown
        if (state_ff.stall_cnt != 3'h0) begin
            nxt_state.stall_cnt = state_ff.stall_cnt - 3'h1;
        end

        // Write time elapsed: strobe drops so software can poll it
        if (timer_done) begin
            nxt_state.wstrobe = 1'b0;
            evt[`NVM_EVT_WRITE_DONE] = 1'b1;
        end

        // Fetched byte lands one cycle after the read strobe
        if (state_ff.rstrobe) begin
            nxt_state.data    = arr_rdata;
            nxt_state.rstrobe = 1'b0;
            evt[`NVM_EVT_READ_DONE] = 1'b1;
        end

        // Register writes, only to mapped offsets
        if (wr) begin
            unique case (apb_req.paddr)
                `NVM_OFS_ADDR_LOW: begin
                    nxt_state.addr[7:0] = apb_req.pwdata[7:0];
                    timer_abort = state_ff.wstrobe;
                end
                `NVM_OFS_ADDR_HIGH: begin
                    nxt_state.addr[8] = apb_req.pwdata[0];
                    timer_abort = state_ff.wstrobe;
                end
                `NVM_OFS_DATA: begin
                    nxt_state.data = apb_req.pwdata[7:0];
                    timer_abort = state_ff.wstrobe;
                end
                `NVM_OFS_CTRL: begin
                    nxt_state.rie = apb_req.pwdata[`NVM_CTRL_RIE_BIT];
                    // Arming needs the strobe written zero in the same access
                    if (apb_req.pwdata[`NVM_CTRL_ARM_BIT] &&
                        !apb_req.pwdata[`NVM_CTRL_WRITE_BIT]) begin
                        nxt_state.arm     = 1'b1;
                        nxt_state.arm_cnt = `NVM_ARM_CYCLES;
                    end
                    // Strobe without arm does nothing
                    if (apb_req.pwdata[`NVM_CTRL_WRITE_BIT] && state_ff.arm &&
                        !state_ff.wstrobe) begin
                        timer_start         = 1'b1;
                        nxt_state.wstrobe   = 1'b1;
                        nxt_state.stall_cnt = `NVM_WRITE_STALL;
                    end else if (apb_req.pwdata[`NVM_CTRL_READ_BIT] &&
                                 !state_ff.wstrobe) begin
                        // Reads are refused while a write runs
                        nxt_state.rstrobe   = 1'b1;
                        nxt_state.stall_cnt = `NVM_READ_STALL;
                    end
                end
                `NVM_OFS_IRQ_STATUS: clr = apb_req.pwdata[2:0];
                `NVM_OFS_IRQ_MASK:   nxt_state.mask = apb_req.pwdata[2:0];
                default: begin
                    // Unmapped: answered with an error, nothing stored
                end
            endcase
        end

        // Aborted write is dropped and its cell keeps the old byte
        if (timer_abort) begin
            nxt_state.wstrobe = 1'b0;
            evt[`NVM_EVT_WRITE_ABORT] = 1'b1;
        end

        // A new event wins over a clear in the same cycle
        nxt_state.status = (state_ff.status & ~clr) | evt;
        nxt_state.stall  = (nxt_state.stall_cnt != 3'h0);
        nxt_state.rdy_irq = global_irq_enable && nxt_state.rie && !nxt_state.wstrobe;
        nxt_state.irq    = |(nxt_state.status & nxt_state.mask);
    end

    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff      <= '0;
            state_ff.addr <= `NVM_ADDR_RESET;
            state_ff.data <= `NVM_DATA_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Checks on the controller behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Counts are small, so every repetition below stays short to unroll

    // Arm timeout: loaded with four, gone four edges later
    a_arm_load: assert property ($rose(state_ff.arm) |-> state_ff.arm_cnt == 3'h4)
        else $error("arm did not start a four cycle timeout");
    a_arm_expire: assert property (state_ff.arm && state_ff.arm_cnt == 3'h1 &&
        !wr_ctrl |=> !state_ff.arm)
        else $error("arm did not clear at timeout");

    // Arm needs the strobe bit written zero in the same access
    a_arm_refused: assert property (wr_ctrl && apb_req.pwdata[2] &&
        apb_req.pwdata[1] && !state_ff.arm |=> !state_ff.arm)
        else $error("arm set while strobe written one");
    a_arm_taken: assert property (wr_ctrl && apb_req.pwdata[2] &&
        !apb_req.pwdata[1] |=> state_ff.arm && state_ff.arm_cnt == 3'h4)
        else $error("arm not set by a clean arm write");

    // Strobe starts a write only while armed
    a_strobe_unarmed: assert property (wr_ctrl && apb_req.pwdata[1] &&
        !state_ff.arm && !state_ff.wstrobe |=> !state_ff.wstrobe)
        else $error("write started without arm");
    a_strobe_armed: assert property (wr_ctrl && apb_req.pwdata[1] &&
        state_ff.arm && !state_ff.wstrobe |=> state_ff.wstrobe)
        else $error("armed strobe did not start write");

    // Stall lengths after each strobe
    a_write_stall: assert property ($rose(state_ff.wstrobe) |->
        cpu_stall [*2] ##1 !cpu_stall)
        else $error("write stall not two cycles");
    a_read_stall: assert property ($rose(state_ff.rstrobe) |->
        cpu_stall [*4] ##1 !cpu_stall)
        else $error("read stall not four cycles");

    // Read fetch, and its refusal while a write runs
    a_read_fetch: assert property (state_ff.rstrobe |=>
        !state_ff.rstrobe && state_ff.data == $past(arr_rdata))
        else $error("read strobe did not fetch and clear");
    a_read_refused: assert property (wr_ctrl && apb_req.pwdata[0] &&
        state_ff.wstrobe |=> !state_ff.rstrobe)
        else $error("read accepted during a write");

    // Address and data must not drift under a running write
    a_addr_hold: assert property (state_ff.wstrobe && !wr |=>
        $stable(state_ff.addr))
        else $error("address moved during a write");
    a_data_hold: assert property (state_ff.wstrobe && !wr |=>
        $stable(state_ff.data))
        else $error("data moved during a write");
    a_addr_high_bit: assert property (wr && apb_req.paddr == `NVM_OFS_ADDR_HIGH |=>
        state_ff.addr[8] == $past(apb_req.pwdata[0]))
        else $error("address high bit not stored");

    // Write end and abort
    a_write_end: assert property (timer_done |=> !state_ff.wstrobe)
        else $error("strobe stayed set after write time");
    a_write_abort: assert property (state_ff.wstrobe && wr &&
        apb_req.paddr == `NVM_OFS_DATA |=> !state_ff.wstrobe)
        else $error("data write did not abort write");
    a_abort_any: assert property (state_ff.wstrobe && wr &&
        aborts_write(apb_req.paddr) |=> !state_ff.wstrobe)
        else $error("address or data write did not abort write");
    a_abort_flag: assert property (timer_abort |=> state_ff.status[2])
        else $error("abort event not recorded");

    // Register view and ready request
    a_ctrl_upper: assert property (xfer && !apb_req.pwrite &&
        apb_req.paddr == `NVM_OFS_CTRL |-> prdata[31:4] == 28'h0)
        else $error("upper control bits not zero");
    a_ready_req: assert property (ready_irq_req ==
        ($past(global_irq_enable) && state_ff.rie && !state_ff.wstrobe))
        else $error("ready request does not follow enable and strobe");
    a_ready_off: assert property (state_ff.wstrobe |-> !ready_irq_req)
        else $error("ready request raised during a write");

    // Main scenarios the bench should reach
    c_write_done: cover property (timer_done);
    c_write_abort: cover property (timer_abort);
    c_read_done: cover property ($fell(state_ff.rstrobe));
    c_irq_seen: cover property ($rose(irq));
    c_arm_expire: cover property ($fell(state_ff.arm));
endmodule // eeprom_access_control
`default_nettype wire

// file: tb/eeprom_access_control_tb.sv
// Self-checking bench for the nonvolatile access controller over APB
`timescale 1ns/1ps
`default_nettype none
`include "nvm_regs.svh"
// Compare two values, count the check and report a mismatch at once
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("BAD t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module eeprom_access_control_tb;
    import nvm_pkg::*;

    // Short self-timed write so the run stays small
    localparam int WC = 20;

    // One ordinary register case: offset, written word, readback, error flag
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] exp;
        logic        err;
    } row_s;

    // Design inputs and outputs
    logic        core_clk;
    logic        rst;
    apb_req_s    apb_req;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        global_irq_enable;
    logic        cpu_stall;
    logic        ready_irq_req;
    logic        irq;
    // Bench bookkeeping
    int          n_errors;
    int          samples_checked;
    int          cyc;
    int          run;
    int          stall_len;
    logic        chained;

    eeprom_access_control #(.WRITE_CYCLES(WC), .TIMER_W(17)) DUT (
        .core_clk(core_clk), .rst(rst), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
        .cpu_stall(cpu_stall), .ready_irq_req(ready_irq_req), .irq(irq));

    // 40 MHz clock
    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    // Free-running cycle count, used to time the self-timed write
    always @(posedge core_clk) cyc <= cyc + 1;

    // Length of the latest stall pulse, recorded when it ends
    always @(posedge core_clk) begin
        if (cpu_stall === 1'b1) run <= run + 1;
        else if (run != 0) begin
            stall_len <= run;
            run <= 0;
        end
    end

    // Print counts and verdict, then stop
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // One APB transfer; keep holds psel so the next setup follows at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic keep, output logic [31:0] rd, output logic er);
        int i;
        if (!chained) @(posedge core_clk);
        apb_req.psel   <= 1'b1;
        apb_req.pwrite <= wr;
        apb_req.paddr  <= a;
        apb_req.pwdata <= wd;
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        // Bounded wait for the slave answer
        for (i = 0; i < 50; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            n_errors++;
            results();
        end else begin
            rd = prdata;
            er = pslverr;
            apb_req.penable <= 1'b0;
            if (!keep) apb_req.psel <= 1'b0;
            chained = keep;
        end
    endtask

    // Register write and read shorthands
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic keep = 1'b0);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, keep, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, 1'b0, r, e);
    endtask

    // Ordinary cases: field widths, zero upper bits, unmapped offset
    row_s rows [6] = '{
        '{`NVM_OFS_ADDR_LOW,  32'h000001A5, 32'h000000A5, 1'b0},
        '{`NVM_OFS_ADDR_HIGH, 32'h000000FF, 32'h00000001, 1'b0},
        '{`NVM_OFS_DATA,      32'h000001FF, 32'h000000FF, 1'b0},
        '{`NVM_OFS_CTRL,      32'h000000F8, 32'h00000008, 1'b0},
        '{`NVM_OFS_IRQ_MASK,  32'h000000FF, 32'h00000007, 1'b0},
        '{8'h18,              32'h00000055, 32'h00000000, 1'b1}};
    logic [7:0] offs [6] = '{`NVM_OFS_ADDR_LOW, `NVM_OFS_ADDR_HIGH, `NVM_OFS_DATA,
                             `NVM_OFS_CTRL, `NVM_OFS_IRQ_STATUS, `NVM_OFS_IRQ_MASK};

    // Main sequence
    initial begin
        logic [31:0] r;
        logic        e;
        int          t0;
        int          t1;
        int          k;
        rst = 1'b1;
        apb_req = '0;
        global_irq_enable = 1'b0;
        n_errors = 0;
        samples_checked = 0;
        cyc = 0;
        run = 0;
        stall_len = 0;
        chained = 1'b0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        // Reset values: every register and the three processor-side outputs read zero
        `CHK({cpu_stall, ready_irq_req, irq}, 3'h0)
        for (k = 0; k < 6; k++) begin
            rd(offs[k], r);
            `CHK(r, 32'h00000000)
        end
        $display("test reset done");
        // Table of write and readback cases
        for (k = 0; k < 6; k++) begin
            apb(1'b1, rows[k].a, rows[k].d, 1'b0, r, e);
            `CHK(e, rows[k].err)
            apb(1'b0, rows[k].a, 32'h0, 1'b0, r, e);
            `CHK(r, rows[k].exp)
            `CHK(e, rows[k].err)
        end
        $display("test table done");
        // Write protection: unarmed strobe, arm timeout, arm with strobe one
        wr(`NVM_OFS_CTRL, 32'h2);
        rd(`NVM_OFS_CTRL, r);
        `CHK(r, 32'h00000000)
        wr(`NVM_OFS_CTRL, 32'h4, 1'b1);
        rd(`NVM_OFS_CTRL, r);
        `CHK(r, 32'h00000004)
        repeat (4) @(posedge core_clk);
        rd(`NVM_OFS_CTRL, r);
        `CHK(r, 32'h00000000)
        wr(`NVM_OFS_CTRL, 32'h2);
        rd(`NVM_OFS_CTRL, r);
        `CHK(r, 32'h00000000)
        wr(`NVM_OFS_CTRL, 32'h6);
        rd(`NVM_OFS_CTRL, r);
        `CHK(r, 32'h00000000)
        $display("test protection done");
        // Full write to 0x1A5 with interrupts off during the sequence
        stall_len = 0;
        wr(`NVM_OFS_DATA, 32'h5C);
        wr(`NVM_OFS_CTRL, 32'hC, 1'b1);
        wr(`NVM_OFS_CTRL, 32'hA);
        t0 = cyc;
        global_irq_enable <= 1'b1;
        rd(`NVM_OFS_CTRL, r);
        `CHK(r, 32'h0000000A)
        `CHK(stall_len, 2)
        `CHK(ready_irq_req, 1'b0)
        // Poll until the strobe clears, bounded
        for (k = 0; k < 40; k++) begin
            rd(`NVM_OFS_CTRL, r);
            if (r[1] == 1'b0) break;
        end
        t1 = cyc;
        `CHK(r, 32'h00000008)
        `CHK((t1 - t0 >= WC) && (t1 - t0 <= WC + 10), 1'b1)
        repeat (2) @(posedge core_clk);
        `CHK(ready_irq_req, 1'b1)
        rd(`NVM_OFS_IRQ_STATUS, r);
        `CHK(r, 32'h00000001)
        `CHK(irq, 1'b1)
        wr(`NVM_OFS_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b0)
        global_irq_enable <= 1'b0;
        repeat (2) @(posedge core_clk);
        `CHK(ready_irq_req, 1'b0)
        $display("test write done");
        // Abort a running write by a data write; the event is masked at first
        wr(`NVM_OFS_IRQ_MASK, 32'h3);
        wr(`NVM_OFS_DATA, 32'h33);
        wr(`NVM_OFS_CTRL, 32'h4, 1'b1);
        wr(`NVM_OFS_CTRL, 32'h2);
        wr(`NVM_OFS_DATA, 32'h77);
        rd(`NVM_OFS_CTRL, r);
        `CHK(r, 32'h00000000)
        rd(`NVM_OFS_IRQ_STATUS, r);
        `CHK(r, 32'h00000004)
        `CHK(irq, 1'b0)
        wr(`NVM_OFS_IRQ_MASK, 32'h7);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b1)
        wr(`NVM_OFS_IRQ_STATUS, 32'h4);
        $display("test abort done");
        // Read back 0x1A5: the aborted write left the cell alone
        stall_len = 0;
        wr(`NVM_OFS_CTRL, 32'h1);
        rd(`NVM_OFS_CTRL, r);
        `CHK(r, 32'h00000000)
        repeat (4) @(posedge core_clk);
        `CHK(stall_len, 4)
        rd(`NVM_OFS_DATA, r);
        `CHK(r, 32'h0000005C)
        rd(`NVM_OFS_IRQ_STATUS, r);
        `CHK(r, 32'h00000002)
        // Same low byte, high bit zero: a different, untouched cell
        wr(`NVM_OFS_ADDR_HIGH, 32'h0);
        wr(`NVM_OFS_CTRL, 32'h1);
        rd(`NVM_OFS_DATA, r);
        `CHK(r, 32'h00000000)
        $display("test read done");
        results();
    end
endmodule // eeprom_access_control_tb
`default_nettype wire
